// >>> core/dmsa_core.sv
// sectored data memory: address decode, pointers, special and general storage
`timescale 1ns/1ns
`default_nettype none
`include "dmsa_defines.svh"
module dmsa_core
  import dmsa_pkg::*;
#(
  parameter int SECTORS = `DMSA_NUM_SECTORS,
  parameter logic [255:0] SFR_RO_MASK = `DMSA_RO_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic acc_valid_in,
  input wire logic acc_ext_in,
  input wire logic [`DMSA_ADDR_W-1:0] acc_addr_in,
  input wire logic acc_write_in,
  input wire logic [`DMSA_DATA_W-1:0] acc_wdata_in,
  input wire logic acc_bitop_in,
  input wire logic [2:0] acc_bit_sel_in,
  input wire logic acc_bit_val_in,
  output logic rd_valid_out,
  output logic [`DMSA_DATA_W-1:0] rd_data_out,
  output logic wr_dropped_out
);
  localparam int SEC_W = $clog2(SECTORS);
  localparam int SFR_N = `DMSA_SFR_SECTORS * 128;

  generate
    if (SECTORS != 2 && SECTORS != 4 && SECTORS != 8) begin : g_bad_sectors
      $error("dmsa_core: SECTORS must be 2, 4 or 8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pointer registers
  logic [7:0] ptr_a_q;
  logic [7:0] ptr_b_off_q;
  logic [7:0] ptr_b_sec_q;
  logic [7:0] ptr_c_off_q;
  logic [7:0] ptr_c_sec_q;

  ////////////////////////////////////////////////////////////////////////////
  // address resolution
  logic [`DMSA_ADDR_W-1:0] dir_addr;
  logic [`DMSA_ADDR_W-1:0] eff_addr;
  logic sec_ok;
  dmsa_path_type path;
  dmsa_target_type kind;

  dmsa_addr_resolve #(
    .SECTORS(SECTORS)
  ) u_resolve (
    .ext_in(acc_ext_in),
    .addr_in(acc_addr_in),
    .ptr_a_in(ptr_a_q),
    .ptr_b_off_in(ptr_b_off_q),
    .ptr_b_sec_in(ptr_b_sec_q),
    .ptr_c_off_in(ptr_c_off_q),
    .ptr_c_sec_in(ptr_c_sec_q),
    .dir_addr_out(dir_addr),
    .eff_addr_out(eff_addr),
    .sec_ok_out(sec_ok),
    .path_out(path),
    .kind_out(kind)
  );

  logic [7:0] eff_ofs;
  logic [7:0] sfr_idx;
  logic is_ptr_loc;
  logic sfr_ro;

  assign eff_ofs = eff_addr[7:0];
  assign sfr_idx = {eff_addr[8], eff_addr[6:0]};
  assign is_ptr_loc = (eff_addr[10:8] == 3'h0) &&
                      (eff_ofs == `DMSA_OFS_PTR_A || eff_ofs == `DMSA_OFS_PTR_B_OFF ||
                       eff_ofs == `DMSA_OFS_PTR_B_SEC || eff_ofs == `DMSA_OFS_PTR_C_OFF ||
                       eff_ofs == `DMSA_OFS_PTR_C_SEC);
  assign sfr_ro = SFR_RO_MASK[sfr_idx];

  ////////////////////////////////////////////////////////////////////////////
  // storage read
  logic [`DMSA_DATA_W-1:0] gp_rdata;
  logic [`DMSA_DATA_W-1:0] sfr_q [SFR_N];
  logic [`DMSA_DATA_W-1:0] cur_byte;
  logic [`DMSA_DATA_W-1:0] ptr_rdata;

  always_comb begin
    unique case (eff_ofs)
      `DMSA_OFS_PTR_A: ptr_rdata = ptr_a_q;
      `DMSA_OFS_PTR_B_OFF: ptr_rdata = ptr_b_off_q;
      `DMSA_OFS_PTR_B_SEC: ptr_rdata = ptr_b_sec_q;
      `DMSA_OFS_PTR_C_OFF: ptr_rdata = ptr_c_off_q;
      `DMSA_OFS_PTR_C_SEC: ptr_rdata = ptr_c_sec_q;
      default: ptr_rdata = `DMSA_UNUSED_FILL;
    endcase
  end

  always_comb begin
    unique case (kind)
      DMSA_TGT_GP: cur_byte = gp_rdata;
      DMSA_TGT_SFR: cur_byte = is_ptr_loc ? ptr_rdata : sfr_q[sfr_idx];
      DMSA_TGT_PORT: cur_byte = `DMSA_UNUSED_FILL;
      DMSA_TGT_NONE: cur_byte = `DMSA_UNUSED_FILL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path
  logic [`DMSA_DATA_W-1:0] bit_mask;
  logic [`DMSA_DATA_W-1:0] wr_byte;
  logic wr_req;
  logic wr_ok;
  logic gp_we;
  logic sfr_we;
  logic ptr_we;

  assign bit_mask = 8'h01 << acc_bit_sel_in;
  // bit ops are read-modify-write of the resolved byte in one cycle
  assign wr_byte = acc_bitop_in ?
                   ((cur_byte & ~bit_mask) | (acc_bit_val_in ? bit_mask : 8'h00)) :
                   acc_wdata_in;
  assign wr_req = acc_valid_in && (acc_write_in || acc_bitop_in);
  // ports, unused and protected locations swallow the write
  assign wr_ok = wr_req && (kind == DMSA_TGT_GP ||
                            (kind == DMSA_TGT_SFR && !sfr_ro));
  assign gp_we = wr_ok && kind == DMSA_TGT_GP;
  assign sfr_we = wr_ok && kind == DMSA_TGT_SFR && !is_ptr_loc;
  assign ptr_we = wr_ok && kind == DMSA_TGT_SFR && is_ptr_loc;

  dmsa_gp_ram #(
    .SECTORS(SECTORS),
    .IDX_W(SEC_W + 7)
  ) u_gp_ram (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(gp_we),
    .wr_idx_in({eff_addr[SEC_W+7:8], eff_addr[6:0]}),
    .wr_data_in(wr_byte),
    .rd_idx_in({eff_addr[SEC_W+7:8], eff_addr[6:0]}),
    .rd_data_out(gp_rdata)
  );

  genvar gi;
  generate
    for (gi = 0; gi < SFR_N; gi++) begin : g_sfr
      always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          sfr_q[gi] <= `DMSA_SFR_RESET;
        end else if (sfr_we && sfr_idx == 8'(gi)) begin
          sfr_q[gi] <= wr_byte;
        end
      end
    end
  endgenerate

  // pointers are ordinary registers and may also be hit through a port
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_a_q <= `DMSA_PTR_RESET;
      ptr_b_off_q <= `DMSA_PTR_RESET;
      ptr_b_sec_q <= `DMSA_PTR_RESET;
      ptr_c_off_q <= `DMSA_PTR_RESET;
      ptr_c_sec_q <= `DMSA_PTR_RESET;
    end else if (ptr_we) begin
      if (eff_ofs == `DMSA_OFS_PTR_A) ptr_a_q <= wr_byte;
      if (eff_ofs == `DMSA_OFS_PTR_B_OFF) ptr_b_off_q <= wr_byte;
      if (eff_ofs == `DMSA_OFS_PTR_B_SEC) ptr_b_sec_q <= wr_byte;
      if (eff_ofs == `DMSA_OFS_PTR_C_OFF) ptr_c_off_q <= wr_byte;
      if (eff_ofs == `DMSA_OFS_PTR_C_SEC) ptr_c_sec_q <= wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= `DMSA_UNUSED_FILL;
    end else begin
      rd_valid_out <= acc_valid_in && !acc_write_in && !acc_bitop_in;
      if (acc_valid_in && !acc_write_in && !acc_bitop_in) begin
        rd_data_out <= cur_byte;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_dropped_out <= 1'b0;
    end else begin
      wr_dropped_out <= wr_req && !wr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic rd_req;
  assign rd_req = acc_valid_in && !acc_write_in && !acc_bitop_in;

  property p_port_a_sector0;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && path == DMSA_PATH_A |-> eff_addr == {3'h0, ptr_a_q};
  endproperty
  a_port_a_sector0: assert property (p_port_a_sector0)
    else $error("port a left sector 0");

  property p_port_b_pair;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && path == DMSA_PATH_B |->
        eff_addr[10:8] == ptr_b_sec_q[2:0] && eff_ofs == ptr_b_off_q;
  endproperty
  a_port_b_pair: assert property (p_port_b_pair)
    else $error("port b not steered by its pointer pair");

  property p_port_c_pair;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && path == DMSA_PATH_C |->
        eff_addr[10:8] == ptr_c_sec_q[2:0] && eff_ofs == ptr_c_off_q;
  endproperty
  a_port_c_pair: assert property (p_port_c_pair)
    else $error("port c not steered by its pointer pair");

  property p_ext_sector;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && acc_ext_in && path == DMSA_PATH_DIRECT |->
        eff_addr == acc_addr_in;
  endproperty
  a_ext_sector: assert property (p_ext_sector)
    else $error("extended operand not decoded as sector and offset");

  property p_ext_zero_same;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && acc_ext_in && acc_addr_in[10:8] == 3'h0 |->
        dir_addr == {3'h0, acc_addr_in[7:0]};
  endproperty
  a_ext_zero_same: assert property (p_ext_zero_same)
    else $error("extended sector 0 differs from standard access");

  property p_unused_zero;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      rd_req && (kind == DMSA_TGT_NONE || kind == DMSA_TGT_PORT) |=>
        rd_valid_out && rd_data_out == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused or port location did not read 00");

  // byte under the current access, kept so a protected write can be proven harmless
  logic [7:0] ro_idx_q;
  logic [`DMSA_DATA_W-1:0] ro_byte_q;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ro_idx_q <= 8'h00;
      ro_byte_q <= `DMSA_SFR_RESET;
    end else begin
      ro_idx_q <= sfr_idx;
      ro_byte_q <= sfr_q[sfr_idx];
    end
  end

  property p_ro_ignored;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      wr_req && kind == DMSA_TGT_SFR && sfr_ro |=>
        wr_dropped_out && sfr_q[ro_idx_q] == ro_byte_q;
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)
    else $error("write to protected register took effect");

  property p_gp_readback;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (acc_valid_in && acc_write_in && !acc_bitop_in && kind == DMSA_TGT_GP)
      ##1 (rd_req && eff_addr == $past(eff_addr)) |=>
        rd_valid_out && rd_data_out == $past(acc_wdata_in, 2);
  endproperty
  a_gp_readback: assert property (p_gp_readback)
    else $error("general purpose byte did not read back");

  property p_half_split;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && kind != DMSA_TGT_NONE |->
        (kind == DMSA_TGT_GP) == eff_addr[`DMSA_GP_BIT];
  endproperty
  a_half_split: assert property (p_half_split)
    else $error("special and general halves confused");

  property p_read_latency;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      rd_req |=> rd_valid_out ##1 (rd_valid_out == $past(rd_req));
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not one cycle after request");

  property p_port_write_dropped;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      wr_req && kind == DMSA_TGT_PORT |=>
        wr_dropped_out;
  endproperty
  a_port_write_dropped: assert property (p_port_write_dropped)
    else $error("write to an indirect port was not dropped");

  property p_unused_write_dropped;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      wr_req && kind == DMSA_TGT_NONE |=>
        wr_dropped_out;
  endproperty
  a_unused_write_dropped: assert property (p_unused_write_dropped)
    else $error("write to an unused location was not dropped");

  property p_gp_write_lands;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      wr_req && kind == DMSA_TGT_GP |=>
        !wr_dropped_out;
  endproperty
  a_gp_write_lands: assert property (p_gp_write_lands)
    else $error("general purpose write was refused");

  property p_sfr_write_lands;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      wr_req && kind == DMSA_TGT_SFR && !sfr_ro |=>
        !wr_dropped_out;
  endproperty
  a_sfr_write_lands: assert property (p_sfr_write_lands)
    else $error("writable special register refused a write");

  property p_no_bank_reg;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && !acc_ext_in && path == DMSA_PATH_DIRECT |->
        eff_addr[10:8] == 3'h0;
  endproperty
  a_no_bank_reg: assert property (p_no_bank_reg)
    else $error("standard direct access left sector 0");

  property p_ext_reach;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && acc_ext_in && path == DMSA_PATH_DIRECT && acc_addr_in[7] &&
      32'(acc_addr_in[10:8]) < SECTORS |->
        kind == DMSA_TGT_GP;
  endproperty
  a_ext_reach: assert property (p_ext_reach)
    else $error("extended operand did not reach its general byte");

  property p_port_b_reach;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && path == DMSA_PATH_B && ptr_b_sec_q[7:3] == 5'h00 && ptr_b_off_q[7] &&
      32'(ptr_b_sec_q[2:0]) < SECTORS |->
        kind == DMSA_TGT_GP;
  endproperty
  a_port_b_reach: assert property (p_port_b_reach)
    else $error("port b did not reach its general byte");

  property p_port_c_reach;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      acc_valid_in && path == DMSA_PATH_C && ptr_c_sec_q[7:3] == 5'h00 && ptr_c_off_q[7] &&
      32'(ptr_c_sec_q[2:0]) < SECTORS |->
        kind == DMSA_TGT_GP;
  endproperty
  a_port_c_reach: assert property (p_port_c_reach)
    else $error("port c did not reach its general byte");
endmodule : dmsa_core
`default_nettype wire

// >>> core/dmsa_defines.svh
// constants for the sectored data memory address decoder
`ifndef DMSA_DEFINES_SVH
`define DMSA_DEFINES_SVH

`define DMSA_ADDR_W 11
`define DMSA_DATA_W 8
`define DMSA_NUM_SECTORS 8
`define DMSA_SFR_SECTORS 2
`define DMSA_GP_BIT 7
`define DMSA_OFS_PORT_A 8'h00
`define DMSA_OFS_PTR_A 8'h01
`define DMSA_OFS_PORT_B 8'h02
`define DMSA_OFS_PTR_B_OFF 8'h03
`define DMSA_OFS_PTR_B_SEC 8'h04
`define DMSA_OFS_PORT_C 8'h0C
`define DMSA_OFS_PTR_C_OFF 8'h0D
`define DMSA_OFS_PTR_C_SEC 8'h0E
`define DMSA_PTR_RESET 8'h00
`define DMSA_SFR_RESET 8'h00
`define DMSA_UNUSED_FILL 8'h00
`define DMSA_S0_LAST_USED 7'h78
`define DMSA_S0_HOLE_A 7'h40
`define DMSA_S0_HOLE_B 7'h59
`define DMSA_S1_PTM_FIRST 7'h37
`define DMSA_S1_PTM_LAST 7'h3E
`define DMSA_S1_EE_CTRL 7'h40
`define DMSA_S1_UART_FIRST 7'h4C
`define DMSA_S1_UART_LAST 7'h5D
`define DMSA_RO_DEFAULT 256'h100
`define DMSA_READ_LATENCY 1

`endif

// >>> core/dmsa_pkg.sv
// types shared by the data memory address decoder
package dmsa_pkg;
  typedef enum logic [1:0] {
    DMSA_TGT_GP = 2'b00,
    DMSA_TGT_SFR = 2'b01,
    DMSA_TGT_PORT = 2'b10,
    DMSA_TGT_NONE = 2'b11
  } dmsa_target_type;

  typedef enum logic [1:0] {
    DMSA_PATH_DIRECT = 2'b00,
    DMSA_PATH_A = 2'b01,
    DMSA_PATH_B = 2'b10,
    DMSA_PATH_C = 2'b11
  } dmsa_path_type;
endpackage : dmsa_pkg

// >>> core/dmsa_gp_ram.sv
// general purpose ram, upper half of every sector
`timescale 1ns/1ns
`default_nettype none
`include "dmsa_defines.svh"
module dmsa_gp_ram #(
  parameter int SECTORS = `DMSA_NUM_SECTORS,
  parameter int IDX_W = $clog2(SECTORS) + 7
) (
  input wire logic sys_clk_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [`DMSA_DATA_W-1:0] wr_data_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [`DMSA_DATA_W-1:0] rd_data_out
);
  logic [`DMSA_DATA_W-1:0] mem [SECTORS*128];

  // no reset: plain ram contents are undefined at power up
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_idx_in];
endmodule : dmsa_gp_ram
`default_nettype wire

// >>> core/dmsa_addr_resolve.sv
// resolves an operand address into an effective sector/offset and target kind
`timescale 1ns/1ns
`default_nettype none
`include "dmsa_defines.svh"
module dmsa_addr_resolve
  import dmsa_pkg::*;
#(
  parameter int SECTORS = `DMSA_NUM_SECTORS
) (
  input wire logic ext_in,
  input wire logic [`DMSA_ADDR_W-1:0] addr_in,
  input wire logic [7:0] ptr_a_in,
  input wire logic [7:0] ptr_b_off_in,
  input wire logic [7:0] ptr_b_sec_in,
  input wire logic [7:0] ptr_c_off_in,
  input wire logic [7:0] ptr_c_sec_in,
  output logic [`DMSA_ADDR_W-1:0] dir_addr_out,
  output logic [`DMSA_ADDR_W-1:0] eff_addr_out,
  output logic sec_ok_out,
  output dmsa_path_type path_out,
  output dmsa_target_type kind_out
);
  logic [2:0] sec;
  logic [6:0] low;

  // standard operands carry a byte only; extended ones carry sector too
  assign dir_addr_out = ext_in ? addr_in : {3'h0, addr_in[7:0]};

  // only pointer pairs b and c and extended operands pick a sector; no data bank register exists
  always_comb begin
    path_out = DMSA_PATH_DIRECT;
    eff_addr_out = dir_addr_out;
    sec_ok_out = 1'b1;
    if (dir_addr_out[10:8] == 3'h0) begin
      if (dir_addr_out[7:0] == `DMSA_OFS_PORT_A) begin
        path_out = DMSA_PATH_A;
        eff_addr_out = {3'h0, ptr_a_in};
      end else if (dir_addr_out[7:0] == `DMSA_OFS_PORT_B) begin
        path_out = DMSA_PATH_B;
        eff_addr_out = {ptr_b_sec_in[2:0], ptr_b_off_in};
        sec_ok_out = (ptr_b_sec_in[7:3] == 5'h00);
      end else if (dir_addr_out[7:0] == `DMSA_OFS_PORT_C) begin
        path_out = DMSA_PATH_C;
        eff_addr_out = {ptr_c_sec_in[2:0], ptr_c_off_in};
        sec_ok_out = (ptr_c_sec_in[7:3] == 5'h00);
      end
    end
  end

  assign sec = eff_addr_out[10:8];
  assign low = eff_addr_out[6:0];

  always_comb begin
    kind_out = DMSA_TGT_NONE;
    if (!sec_ok_out || 32'(sec) >= SECTORS) begin
      kind_out = DMSA_TGT_NONE;
    end else if (eff_addr_out[`DMSA_GP_BIT]) begin
      kind_out = DMSA_TGT_GP;
    end else if (sec == 3'h0) begin
      if (eff_addr_out[7:0] == `DMSA_OFS_PORT_A || eff_addr_out[7:0] == `DMSA_OFS_PORT_B ||
          eff_addr_out[7:0] == `DMSA_OFS_PORT_C) begin
        kind_out = DMSA_TGT_PORT;
      end else if (low <= `DMSA_S0_LAST_USED && low != `DMSA_S0_HOLE_A &&
                   low != `DMSA_S0_HOLE_B) begin
        kind_out = DMSA_TGT_SFR;
      end
    end else if (sec == 3'h1) begin
      if ((low >= `DMSA_S1_PTM_FIRST && low <= `DMSA_S1_PTM_LAST) ||
          low == `DMSA_S1_EE_CTRL ||
          (low >= `DMSA_S1_UART_FIRST && low <= `DMSA_S1_UART_LAST)) begin
        kind_out = DMSA_TGT_SFR;
      end
    end
  end
endmodule : dmsa_addr_resolve
`default_nettype wire

// >>> testbench/dmsa_cpu_model.sv
// processor core model issuing data memory accesses to the decoder
`timescale 1ns/1ns
`default_nettype none
`include "dmsa_defines.svh"
module dmsa_cpu_model (
  input wire logic sys_clk_in,
  input wire logic rd_valid_in,
  input wire logic [`DMSA_DATA_W-1:0] rd_data_in,
  input wire logic wr_dropped_in,
  output logic valid_out,
  output logic ext_out,
  output logic [`DMSA_ADDR_W-1:0] addr_out,
  output logic write_out,
  output logic [`DMSA_DATA_W-1:0] wdata_out,
  output logic bitop_out,
  output logic [2:0] bit_sel_out,
  output logic bit_val_out
);
  initial begin
    valid_out = 1'b0;
    ext_out = 1'b0;
    addr_out = 11'h000;
    write_out = 1'b0;
    wdata_out = 8'h00;
    bitop_out = 1'b0;
    bit_sel_out = 3'h0;
    bit_val_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one access: called on a falling edge, answer taken at the next one;
  // the request stays up so the next call runs back to back
  task automatic access(input logic ext, input logic [10:0] a, input logic wr,
                        input logic [7:0] wd, input logic bop, input logic [2:0] bs,
                        input logic bv, output logic rv, output logic [7:0] rd,
                        output logic drop);
    valid_out = 1'b1;
    ext_out = ext;
    addr_out = a;
    write_out = wr;
    wdata_out = wd;
    bitop_out = bop;
    bit_sel_out = bs;
    bit_val_out = bv;
    @(negedge sys_clk_in);
    rv = rd_valid_in;
    rd = rd_data_in;
    drop = wr_dropped_in;
  endtask : access

  // idle the request; address and write data scrambled so a stale address never looks valid
  task automatic release_bus();
    valid_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask : release_bus
endmodule : dmsa_cpu_model
`default_nettype wire

// >>> testbench/dmsa_core_test.sv
// self-checking testbench for the sectored data memory decoder
`timescale 1ns/1ns
`default_nettype none
`include "dmsa_defines.svh"
module dmsa_core_test;
  logic sys_clk_in;
  logic resetn_in;
  logic valid, ext, write, bitop, bit_val, rd_valid, wr_dropped;
  logic [10:0] addr;
  logic [7:0] wdata, rd_data;
  logic [2:0] bit_sel;
  int fail_count = 0;
  int checked = 0;

  dmsa_core i_dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .acc_valid_in(valid),
    .acc_ext_in(ext), .acc_addr_in(addr), .acc_write_in(write),
    .acc_wdata_in(wdata), .acc_bitop_in(bitop), .acc_bit_sel_in(bit_sel),
    .acc_bit_val_in(bit_val), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .wr_dropped_out(wr_dropped)
  );

  dmsa_cpu_model i_cpu (
    .sys_clk_in(sys_clk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
    .wr_dropped_in(wr_dropped), .valid_out(valid), .ext_out(ext), .addr_out(addr),
    .write_out(write), .wdata_out(wdata), .bitop_out(bitop), .bit_sel_out(bit_sel),
    .bit_val_out(bit_val)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk1

  task automatic rd(input logic e, input logic [10:0] a, input logic [7:0] exp);
    logic rv;
    logic dr;
    logic [7:0] d;
    i_cpu.access(e, a, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, rv, d, dr);
    chk1(rv, 1'b1);
    chk1(dr, 1'b0);
    chk8(d, exp);
  endtask : rd

  task automatic wr(input logic e, input logic [10:0] a, input logic [7:0] d,
                    input logic drop);
    logic rv;
    logic dr;
    logic [7:0] q;
    i_cpu.access(e, a, 1'b1, d, 1'b0, 3'h0, 1'b0, rv, q, dr);
    chk1(rv, 1'b0);
    chk1(dr, drop);
  endtask : wr

  task automatic bop(input logic [10:0] a, input logic [2:0] s, input logic v);
    logic rv;
    logic dr;
    logic [7:0] q;
    i_cpu.access(1'b0, a, 1'b0, 8'hFF, 1'b1, s, v, rv, q, dr);
    chk1(rv, 1'b0);
    chk1(dr, 1'b0);
  endtask : bop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    resetn_in = 1'b1;
    // pointers and special storage come up cleared
    rd(1'b0, 11'h001, 8'h00);
    rd(1'b0, 11'h004, 8'h00);
    rd(1'b0, 11'h00E, 8'h00);
    rd(1'b0, 11'h010, 8'h00);
    // general area and single-bit operations
    wr(1'b0, 11'h085, 8'hA5, 1'b0);
    rd(1'b0, 11'h085, 8'hA5);
    bop(11'h085, 3'h0, 1'b0);
    bop(11'h085, 3'h6, 1'b1);
    rd(1'b0, 11'h085, 8'hE4);
    // extended operands: sector in the high part, offset in the low byte
    wr(1'b0, 11'h090, 8'h11, 1'b0);
    wr(1'b1, 11'h390, 8'h3C, 1'b0);
    wr(1'b1, 11'h790, 8'h77, 1'b0);
    rd(1'b0, 11'h090, 8'h11);
    rd(1'b1, 11'h090, 8'h11);
    rd(1'b1, 11'h390, 8'h3C);
    rd(1'b1, 11'h790, 8'h77);
    // standard operand ignores the sector bits
    rd(1'b0, 11'h790, 8'h11);
    // no data bank select: the code bank register leaves data mapping alone
    wr(1'b0, 11'h00B, 8'h01, 1'b0);
    rd(1'b0, 11'h085, 8'hE4);
    rd(1'b0, 11'h090, 8'h11);
    // pair b reaches sector 3
    wr(1'b0, 11'h003, 8'h90, 1'b0);
    wr(1'b0, 11'h004, 8'h03, 1'b0);
    rd(1'b0, 11'h002, 8'h3C);
    wr(1'b0, 11'h002, 8'h5A, 1'b0);
    rd(1'b1, 11'h390, 8'h5A);
    rd(1'b0, 11'h003, 8'h90);
    // pair c reaches sector 7
    wr(1'b0, 11'h00D, 8'h90, 1'b0);
    wr(1'b0, 11'h00E, 8'h07, 1'b0);
    rd(1'b0, 11'h00C, 8'h77);
    // pair b with a sector byte past the last sector reaches nothing
    wr(1'b0, 11'h004, 8'h08, 1'b0);
    wr(1'b0, 11'h002, 8'h99, 1'b1);
    rd(1'b0, 11'h002, 8'h00);
    // port a: sector 0 only
    wr(1'b0, 11'h001, 8'h85, 1'b0);
    rd(1'b0, 11'h000, 8'hE4);
    wr(1'b0, 11'h000, 8'h42, 1'b0);
    rd(1'b0, 11'h085, 8'h42);
    // pointers aimed at a port: reads give zero, writes do nothing
    wr(1'b0, 11'h001, 8'h00, 1'b0);
    rd(1'b0, 11'h000, 8'h00);
    wr(1'b0, 11'h000, 8'h33, 1'b1);
    wr(1'b0, 11'h003, 8'h0C, 1'b0);
    wr(1'b0, 11'h004, 8'h00, 1'b0);
    rd(1'b0, 11'h002, 8'h00);
    // special area: plain, protected and unused places
    wr(1'b0, 11'h010, 8'h5A, 1'b0);
    rd(1'b0, 11'h010, 8'h5A);
    wr(1'b0, 11'h008, 8'h55, 1'b1);
    rd(1'b0, 11'h008, 8'h00);
    wr(1'b1, 11'h137, 8'h6B, 1'b0);
    rd(1'b1, 11'h137, 8'h6B);
    rd(1'b1, 11'h037, 8'h00);
    wr(1'b0, 11'h07A, 8'hFF, 1'b1);
    rd(1'b0, 11'h07A, 8'h00);
    rd(1'b0, 11'h040, 8'h00);
    rd(1'b1, 11'h141, 8'h00);
    rd(1'b1, 11'h210, 8'h00);
    // reset in mid-run: registers clear, plain ram keeps its contents
    i_cpu.release_bus();
    resetn_in = 1'b0;
    @(negedge sys_clk_in);
    resetn_in = 1'b1;
    rd(1'b0, 11'h003, 8'h00);
    rd(1'b0, 11'h010, 8'h00);
    rd(1'b1, 11'h390, 8'h5A);
    results();
  end

  // watchdog: the sequence needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end
endmodule : dmsa_core_test
`default_nettype wire
